// *** core/nqd_regs.vh ***
`ifndef NQD_REGS_VH
`define NQD_REGS_VH
// ==========================================
// Register word indices, matched to avs_address (byte offsets = 4 x index)
`define NQD_IDX_CTRL 8'h80
`define NQD_IDX_TUNE0 8'h82
`define NQD_IDX_TUNE3 8'h85
`define NQD_IDX_PHASE0 8'h86
`define NQD_IDX_PHASE_LAST 8'h95
`define NQD_IDX_MODE 8'h96
`define NQD_IDX_STATUS 8'h97
// ==========================================
// Control register fields
`define NQD_CTRL_FIRST_MIXER 0
`define NQD_CTRL_FS8 1
`define NQD_CTRL_HB_A 2
`define NQD_CTRL_HB_B 3
`define NQD_CTRL_AMP_DITH 4
`define NQD_CTRL_OSC_EN 5
`define NQD_CTRL_PHS_DITH 6
`define NQD_CTRL_RESET 8'h00
// Mode register fields
`define NQD_MODE_DUAL 0
`define NQD_MODE_DER_LSB 1
`define NQD_MODE_DER_MSB 3
`define NQD_MODE_RESET 8'h00
// ==========================================
// Timing
`define NQD_HB_GROUP_DELAY 40
`define NQD_HB_DECIM 2
`define NQD_HB_DELAY (`NQD_HB_GROUP_DELAY * `NQD_HB_DECIM)
`define NQD_TUNE_RESET 32'h0000_0000
`define NQD_PHASE_RESET 16'h0000
`endif

// *** core/nqd_downconverter.v ***
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "nqd_regs.vh"
module nqd_downconverter (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // ADC samples in
  input wire [15:0] adc_ch0,
  input wire [15:0] adc_ch1,
  input wire adc_valid,
  // Output stream
  output reg [15:0] out_data,
  output reg out_valid,
  output reg word_clock
);
  // ==========================================
  // Functions
  // Quarter-wave-free sine approximation: triangle folded to 16 bits
  function [15:0] sin_lut;
    input [15:0] ph;
    reg [15:0] fold;
    begin
      fold = ph[14] ? ~{ph[13:0], 2'b00} : {ph[13:0], 2'b00};
      sin_lut = ph[15] ? (16'h0000 - {1'b0, fold[15:1]}) : {1'b0, fold[15:1]};
    end
  endfunction

  // Cosine is the sine a quarter turn ahead
  function [15:0] cos_lut;
    input [15:0] ph;
    begin
      cos_lut = sin_lut(ph + 16'h4000);
    end
  endfunction

  // One tap pair: sum for low-pass, difference for high-pass
  function [15:0] hb_tap;
    input [15:0] cur;
    input [15:0] prev;
    input hp;
    begin
      hb_tap = hp ? (cur - prev) : (cur + prev);
    end
  endfunction

  // Clears the least significant bit of a filtered word
  function [15:0] hb_trim;
    input [15:0] w;
    begin
      hb_trim = {w[15:1], 1'b0};
    end
  endfunction

  // Maximal-length shift register step for dither
  function [15:0] lfsr_step;
    input [15:0] s;
    begin
      lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    end
  endfunction

  function [15:0] mul_q15;
    input [15:0] a;
    input [15:0] b;
    reg [31:0] p;
    begin
      p = $signed(a) * $signed(b);
      mul_q15 = p[30:15];
    end
  endfunction
  // ==========================================
  // Registers
  reg [7:0] ctrl_reg;
  reg [7:0] mode_reg;
  reg [31:0] tune_shadow_reg;
  reg [31:0] tune_reg;
  reg [7:0] phase_shadow_reg [0:15];
  reg [15:0] phase_reg [0:7];
  reg rd_pend_reg;
  reg [31:0] acc_reg;
  integer i;
  integer k;
  wire [7:0] idx = avs_address;
  wire [7:0] wbyte = avs_writedata[7:0];
  wire wr_en = avs_write && avs_byteenable[0];
  wire phase_hit = (idx >= `NQD_IDX_PHASE0) && (idx <= `NQD_IDX_PHASE_LAST);
  wire [3:0] phase_sel = idx[3:0] - 4'h6;
  wire [2:0] phase_chan = phase_sel[3:1];
  wire phase_hi_byte = phase_sel[0];
  wire ctrl_hit = (idx == `NQD_IDX_CTRL);
  wire mode_hit = (idx == `NQD_IDX_MODE);
  wire tune_hit = (idx >= `NQD_IDX_TUNE0) && (idx <= `NQD_IDX_TUNE3);
  wire rd_take = avs_read && !rd_pend_reg;

  // ==========================================
  // Readback mux
  function [31:0] reg_readback;
    input [7:0] a;
    begin
      reg_readback = 32'h0000_0000;
      if (ctrl_hit) begin
        reg_readback = {24'h00_0000, ctrl_reg};
      end else if (mode_hit) begin
        reg_readback = {24'h00_0000, mode_reg};
      end else if (tune_hit) begin
        case (a[1:0])
          2'd2: reg_readback = {24'h00_0000, tune_shadow_reg[7:0]};
          2'd3: reg_readback = {24'h00_0000, tune_shadow_reg[15:8]};
          2'd0: reg_readback = {24'h00_0000, tune_shadow_reg[23:16]};
          default: reg_readback = {24'h00_0000, tune_shadow_reg[31:24]};
        endcase
      end else if (phase_hit) begin
        reg_readback = {24'h00_0000, phase_shadow_reg[phase_sel]};
      end else if (a == `NQD_IDX_STATUS) begin
        reg_readback = {16'h0000, acc_reg[31:16]};
      end
    end
  endfunction

  // Reads take one wait cycle
  assign avs_waitrequest = avs_read && !rd_pend_reg;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg <= `NQD_CTRL_RESET;
      mode_reg <= `NQD_MODE_RESET;
      tune_shadow_reg <= `NQD_TUNE_RESET;
      tune_reg <= `NQD_TUNE_RESET;
      rd_pend_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      for (i = 0; i < 16; i = i + 1) begin
        phase_shadow_reg[i] <= 8'h00;
      end
      for (i = 0; i < 8; i = i + 1) begin
        phase_reg[i] <= `NQD_PHASE_RESET;
      end
    end else begin
      rd_pend_reg <= avs_read && !rd_pend_reg;
      if (wr_en) begin
        if (idx == `NQD_IDX_CTRL) begin
          ctrl_reg <= wbyte;
        end
        if (idx == `NQD_IDX_MODE) begin
          mode_reg <= wbyte;
        end
        if (idx >= `NQD_IDX_TUNE0 && idx <= `NQD_IDX_TUNE3) begin
          case (idx[1:0])
            2'd2: tune_shadow_reg[7:0] <= wbyte;
            2'd3: tune_shadow_reg[15:8] <= wbyte;
            2'd0: tune_shadow_reg[23:16] <= wbyte;
            default: begin
              // Top byte commits whole word
              tune_reg <= {wbyte, tune_shadow_reg[23:0]};
              tune_shadow_reg[31:24] <= wbyte;
            end
          endcase
        end
        if (phase_hit) begin
          phase_shadow_reg[phase_sel] <= wbyte;
          if (phase_hi_byte) begin
            // High byte commits channel offset
            phase_reg[phase_chan] <= {wbyte, phase_shadow_reg[{phase_chan, 1'b0}]};
          end
        end
      end
      if (rd_take) begin
        avs_readdata <= reg_readback(idx);
      end
    end
  end
  // ==========================================
  // Oscillator and dither
  reg [15:0] lfsr_reg;
  wire osc_on = ctrl_reg[`NQD_CTRL_OSC_EN];
  wire dual = mode_reg[`NQD_MODE_DUAL];
  wire [2:0] der_log = mode_reg[`NQD_MODE_DER_MSB:`NQD_MODE_DER_LSB];
  wire [15:0] pdith = ctrl_reg[`NQD_CTRL_PHS_DITH] ? {13'h0000, lfsr_reg[2:0]} : 16'h0000;
  wire [15:0] adith = ctrl_reg[`NQD_CTRL_AMP_DITH] ? {15'h0000, lfsr_reg[7]} : 16'h0000;
  // Offset added to upper half, 2^16 steps per turn
  wire [15:0] ph0 = acc_reg[31:16] + phase_reg[0] + pdith;
  wire [15:0] ph1 = acc_reg[31:16] + phase_reg[1] + pdith;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_reg <= 32'h0000_0000;
      lfsr_reg <= 16'hACE1;
    end else if (adc_valid) begin
      acc_reg <= osc_on ? acc_reg + tune_reg : 32'h0000_0000;
      lfsr_reg <= lfsr_step(lfsr_reg);
    end
  end
  // ==========================================
  // First mixer
  wire mix_on = ctrl_reg[`NQD_CTRL_FIRST_MIXER];
  // Products before the bypass select
  wire [15:0] mi0 = mul_q15(adc_ch0, cos_lut(ph0)) + adith;
  wire [15:0] mq0 = mul_q15(adc_ch0, sin_lut(ph0)) + adith;
  wire [15:0] mi1 = mul_q15(adc_ch1, cos_lut(ph1)) + adith;
  wire [15:0] mq1 = mul_q15(adc_ch1, sin_lut(ph1)) + adith;
  wire [15:0] i0 = mix_on ? mi0 : adc_ch0;
  wire [15:0] q0 = mix_on ? mq0 : 16'h0000;
  wire [15:0] i1 = mix_on ? mi1 : adc_ch1;
  wire [15:0] q1 = mix_on ? mq1 : 16'h0000;
  // ==========================================
  // Half-band decimator: sum/difference of sample pairs, 80-cycle delay line
  reg [15:0] pi0_reg;
  reg [15:0] pq0_reg;
  reg [15:0] pi1_reg;
  reg [15:0] pq1_reg;
  reg ph_reg;
  reg [63:0] hb_line [0:`NQD_HB_DELAY-1];
  reg [`NQD_HB_DELAY-1:0] hb_vld_reg;
  wire hp_a = ctrl_reg[`NQD_CTRL_HB_A];
  wire hp_b = ctrl_reg[`NQD_CTRL_HB_B];
  // Path A carries I, path B carries Q
  // Two-tap stand-in; stopband and ripple targets not met here
  wire [15:0] hb_i0 = hb_tap(i0, pi0_reg, hp_a);
  wire [15:0] hb_q0 = hb_tap(q0, pq0_reg, hp_b);
  wire [15:0] hb_i1 = hb_tap(i1, pi1_reg, hp_a);
  wire [15:0] hb_q1 = hb_tap(q1, pq1_reg, hp_b);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ph_reg <= 1'b0;
      pi0_reg <= 16'h0000;
      pq0_reg <= 16'h0000;
      pi1_reg <= 16'h0000;
      pq1_reg <= 16'h0000;
      hb_vld_reg <= {`NQD_HB_DELAY{1'b0}};
    end else begin
      if (adc_valid) begin
        ph_reg <= ~ph_reg;
        pi0_reg <= i0;
        pq0_reg <= q0;
        pi1_reg <= i1;
        pq1_reg <= q1;
      end
      hb_vld_reg <= {hb_vld_reg[`NQD_HB_DELAY-2:0], adc_valid & ph_reg};
    end
    hb_line[0] <= {
      hb_trim(hb_i0),
      hb_trim(hb_q0),
      hb_trim(hb_i1),
      hb_trim(hb_q1)
    };
    for (k = 1; k < `NQD_HB_DELAY; k = k + 1) begin
      hb_line[k] <= hb_line[k-1];
    end
  end
  // ==========================================
  // Second mixer (fs/8 or fs/(8 x EXTRA_DECIMATION_RATE)) and output sequencer
  wire [63:0] hb_out = hb_line[`NQD_HB_DELAY-1];
  wire hb_vld = hb_vld_reg[`NQD_HB_DELAY-1];
  wire fs8 = ctrl_reg[`NQD_CTRL_FS8];
  reg [9:0] rot_reg;
  reg [1:0] seq_reg;
  reg [63:0] hold_reg;
  reg busy_reg;
  // Rotator advances once per 2^der_log decimated samples
  wire [2:0] rot = rot_reg[der_log +: 3];
  wire [15:0] ri0 = hb_out[63:48];
  wire [15:0] rq0 = hb_out[47:32];
  // Real output: I cos - Q sin, eighth-turn steps approximated by quarter points
  reg [15:0] real0;
  always @* begin
    case (rot[2:1])
      2'd0: real0 = ri0;
      2'd1: real0 = 16'h0000 - rq0;
      2'd2: real0 = 16'h0000 - ri0;
      default: real0 = rq0;
    endcase
  end

  // Later words of an I/Q group
  reg [15:0] seq_word;
  always @* begin
    case (seq_reg)
      2'd1: seq_word = hold_reg[47:32];
      2'd2: seq_word = hold_reg[31:16];
      default: seq_word = hold_reg[15:0];
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      rot_reg <= 10'h000;
      seq_reg <= 2'd0;
      hold_reg <= 64'h0000_0000_0000_0000;
      busy_reg <= 1'b0;
      out_data <= 16'h0000;
      out_valid <= 1'b0;
      word_clock <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      if (hb_vld && fs8) begin
        rot_reg <= rot_reg + 10'h001;
        out_data <= real0;
        out_valid <= 1'b1;
        word_clock <= ~word_clock;
      end else if (hb_vld) begin
        hold_reg <= hb_out;
        seq_reg <= 2'd1;
        busy_reg <= 1'b1;
        out_data <= hb_out[63:48];
        out_valid <= 1'b1;
        word_clock <= 1'b1;
      end else if (busy_reg) begin
        out_valid <= 1'b1;
        word_clock <= 1'b0;
        out_data <= seq_word;
        seq_reg <= seq_reg + 2'd1;
        if (!dual || seq_reg == 2'd3) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end
endmodule

// *** testbench/nqd_adc_model.sv ***
`timescale 1ns/1ps
module nqd_adc_model (
  // Clock
  input wire clk_sys,
  // Converter samples
  output logic [15:0] adc_ch0,
  output logic [15:0] adc_ch1,
  output logic adc_valid
);
  initial begin
    adc_ch0 = 16'h0000;
    adc_ch1 = 16'h0000;
    adc_valid = 1'b0;
  end
  // One sample, lines inverted while idle
  task send(input logic [15:0] a, input logic [15:0] b, input int gap);
    adc_ch0 <= a;
    adc_ch1 <= b;
    adc_valid <= 1'b1;
    @(posedge clk_sys);
    adc_ch0 <= ~a;
    adc_ch1 <= ~b;
    adc_valid <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule

// *** testbench/nqd_checker_properties.sv ***
`timescale 1ns/1ps
`include "nqd_regs.vh"
module nqd_checker (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Register bus
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Stream
  input wire adc_valid,
  input wire out_valid,
  input wire word_clock
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait wrong");
  chk_unmapped_zero: assert property ($rose(avs_read) && avs_address < `NQD_IDX_CTRL
    |-> ##1 avs_readdata == 32'h0000_0000) else $error("unmapped read not zero");
  chk_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved");
  chk_wck_valid: assert property ($rose(word_clock) |-> out_valid)
    else $error("word clock rose without word");
  chk_hb_delay: assert property ($rose(out_valid) |-> $past(adc_valid, 81))
    else $error("half-band delay wrong");
  chk_wck_group: assert property ($rose(out_valid) |-> $changed(word_clock))
    else $error("group start unmarked");
  chk_wck_quiet: assert property (!out_valid |-> $stable(word_clock))
    else $error("word clock moved idle");
endmodule
bind nqd_downconverter nqd_checker u_nqd_checker (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_valid(adc_valid),
  .out_valid(out_valid), .word_clock(word_clock));

// *** testbench/tb_nco_quadrature_downconverter.sv ***
`timescale 1ns/1ps
`include "nqd_regs.vh"
module tb_nco_quadrature_downconverter;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, rdata;
  logic [15:0] adc_ch0, adc_ch1, out_data;
  logic avs_waitrequest, adc_valid, out_valid, word_clock, wck_exp;
  logic [17:0] exp_q[$];
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 7;
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  nqd_downconverter u_nqd_downconverter (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .adc_ch0(adc_ch0),
    .adc_ch1(adc_ch1), .adc_valid(adc_valid), .out_data(out_data), .out_valid(out_valid),
    .word_clock(word_clock));
  nqd_adc_model u_nqd_adc_model (.clk_sys(clk_sys), .adc_ch0(adc_ch0), .adc_ch1(adc_ch1),
    .adc_valid(adc_valid));
  task end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task fail(input logic [17:0] got, input logic [17:0] exp);
    mismatches++;
    $display("ERROR %0t got %h exp %h", $time, got, exp);
  endtask
  task cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) fail({2'b00, got}, {2'b00, exp});
  endtask
  task cmp_word(input logic [16:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got[16] !== exp[16] || (exp[17] && got[15:0] !== exp[15:0])) fail({1'b0, got}, exp);
  endtask
  // ====
  // Bus cycles, bounded waits
  task bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin
      fail(18'h0_0000, 18'h0_0001);
      end_of_test();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    rdata = avs_readdata;
    avs_read <= 1'b0;
    cmp_reg(rdata[15:0], exp);
    @(posedge clk_sys);
  endtask
  // ====
  // Stream run, expectations queued per pair
  task run(input int pairs, input logic [7:0] ctrl, input logic dual);
    logic [15:0] s;
    wr(`NQD_IDX_CTRL, ctrl);
    wr(`NQD_IDX_MODE, {7'h00, dual});
    wck_exp = 1'b0;
    repeat (pairs) begin
      if (ctrl[`NQD_CTRL_FS8]) begin
        wck_exp = ~wck_exp;
        exp_q.push_back({1'b0, wck_exp, 16'h0000});
      end else begin
        exp_q.push_back(18'h1_0000);
        exp_q.push_back(18'h2_0000);
        if (dual) exp_q.push_back(18'h2_0000);
        if (dual) exp_q.push_back(18'h0_0000);
      end
      repeat (2) begin
        s = 16'($random(seed));
        u_nqd_adc_model.send(s, ~s, 2 + ($unsigned($random(seed)) % 4));
      end
    end
    for (int n = 0; n < 300 && exp_q.size() > 0; n++) @(posedge clk_sys);
    if (exp_q.size() > 0) begin
      fail(18'h0_0000, 18'h0_0001);
      end_of_test();
    end
  endtask
  always @(posedge clk_sys) begin
    if (!sys_rst && out_valid === 1'b1) begin
      if (exp_q.size() == 0) fail({1'b0, word_clock, out_data}, 18'h0_0000);
      else cmp_word({word_clock, out_data}, exp_q.pop_front());
    end
  end
  initial begin
    logic [7:0] r;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`NQD_IDX_CTRL, {8'h00, `NQD_CTRL_RESET});
    rd(`NQD_IDX_MODE, {8'h00, `NQD_MODE_RESET});
    wr(`NQD_IDX_CTRL, 8'h70);
    wr(`NQD_IDX_TUNE0, 8'h00);
    wr(8'h83, 8'h00);
    wr(8'h84, 8'h01);
    run(1, 8'h70, 1'b0);
    rd(`NQD_IDX_STATUS, 16'h0000);
    wr(`NQD_IDX_TUNE3, 8'h00);
    run(1, 8'h70, 1'b0);
    rd(`NQD_IDX_STATUS, 16'h0002);
    cmp_reg({15'h0000, rdata[15:0] != 16'h0000}, 16'h0001);
    rd(8'h84, 16'h0001);
    run(1, 8'h50, 1'b0);
    rd(`NQD_IDX_STATUS, 16'h0000);
    avs_byteenable <= 4'h2;
    wr(`NQD_IDX_CTRL, 8'hFF);
    avs_byteenable <= 4'h1;
    rd(`NQD_IDX_CTRL, 16'h0050);
    wr(8'h10, 8'hA5);
    rd(8'h10, 16'h0000);
    r = 8'($random(seed));
    wr(`NQD_IDX_PHASE_LAST, r);
    rd(`NQD_IDX_PHASE_LAST, {8'h00, r});
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h40);
    for (int h = 0; h < 4; h++) run(2, {4'h0, h[1:0], 2'b01}, 1'b1);
    run(3, 8'h01, 1'b0);
    run(3, 8'h03, 1'b0);
    end_of_test();
  end
endmodule
